// ===== rcw_map.vh
`ifndef RCW_MAP_VH
`define RCW_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define RCW_ADDR_RSSI_SETTLE   11'h138
`define RCW_ADDR_TEST_CONT     11'h139
`define RCW_ADDR_TRANS_SPEED   11'h13A
`define RCW_ADDR_RX_LOCK       11'h13E
`define RCW_ADDR_TX_LOCK       11'h13F
`define RCW_ADDR_FINE_AMP      11'h307
`define RCW_ADDR_WAKE_CFG_HI   11'h30C
`define RCW_ADDR_WAKE_CFG_LO   11'h30D
`define RCW_ADDR_WAKE_VAL_HI   11'h30E
`define RCW_ADDR_WAKE_VAL_LO   11'h30F
// ****************************************
// field positions
// ****************************************
`define RCW_AMP_PIN_SEL_BIT    7
`define RCW_REPEAT_TX_BIT      1
`define RCW_REPEAT_RX_BIT      0
`define RCW_SPEED_MSB          2
`define RCW_AMP_LEVEL_MSB      5
`define RCW_TRIM_MSB           6
`define RCW_TRIM_LSB           3
`define RCW_DIV_MSB            2
`define RCW_WAKE_ARM_BIT       0
// ****************************************
// reset and decode values
// ****************************************
`define RCW_RST_BYTE           8'h00
`define RCW_SPEED_FAST         3'h1
`define RCW_AMP_LEVEL_MIN      6'h02
`define RCW_TRIM_NOMINAL       4'h5
// ****************************************
// timing
// ****************************************
`define RCW_CLK_PERIOD_NS      25
`define RCW_LOCK_STEP_NS       2000
`define RCW_LOCK_STEP_CYC      (`RCW_LOCK_STEP_NS / `RCW_CLK_PERIOD_NS)
`define RCW_LOCK_DEFAULT_STEPS 8'h20
`endif

// ===== rcw_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"

// Contract
// - pin-select bit routes amp controls to test pins or crystal pins.
// - repeat-transmit bit restarts transmit after each packet sent.
// - repeat-receive bit restarts receive after each packet received.
// - speed code 1 is fast, 0 and 4 normal; others reserved.
// - custom enable uses receive lock count after VCO calibration.
// - transmit lock count used likewise; each count adds 2 us.
// - volatile modem registers are cleared on entering sleep.
// - six-bit fine amp level, reset 0, valid range 2 to 63.
// - coarse-trim codes map to ten documented oscillator frequency states.
// - three-bit divider code selects 1 to 65536 division of 32 kHz.
// - high wake config byte is write-only, reset 0, bit 7 zero.
// - wake timer counts down from reload; zero while armed gives event.
// - high reload byte takes effect only after low byte is written.
module rcw_regs (
  input  wire        clk,
  input  wire        nrst,
  input  wire [10:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        sleep_state,
  input  wire        ext_amp_enable,
  input  wire        ext_pa_ctrl,
  input  wire        ext_lna_ctrl,
  output reg         analog_test_pin_three_out,
  output reg         analog_test_pin_three_oe,
  output reg         analog_test_pin_four_out,
  output reg         analog_test_pin_four_oe,
  output reg         slow_crystal_pin_p_out,
  output reg         slow_crystal_pin_p_oe,
  output reg         slow_crystal_pin_n_out,
  output reg         slow_crystal_pin_n_oe,
  input  wire        tx_packet_done,
  input  wire        rx_packet_done,
  output reg         tx_restart,
  output reg         rx_restart,
  output reg         tx_finish,
  output reg         rx_finish,
  output reg         fast_transition,
  output reg  [7:0]  rssi_settle_delay,
  input  wire        custom_lock_time_enable,
  input  wire        vco_cal_done,
  input  wire        synth_rx_mode,
  output reg         synth_lock_done,
  output reg  [5:0]  amp_target_level,
  output reg  [3:0]  rc_trim_state,
  input  wire        slow_clk_in,
  output reg         wake_event
);

  // ****************************************
  // functions
  // ****************************************
  function [16:0] div_ratio;
    input [2:0] code;
    begin
      case (code)
        3'h0:    div_ratio = 17'h00001;
        3'h1:    div_ratio = 17'h00004;
        3'h2:    div_ratio = 17'h00008;
        3'h3:    div_ratio = 17'h00010;
        3'h4:    div_ratio = 17'h00080;
        3'h5:    div_ratio = 17'h00400;
        3'h6:    div_ratio = 17'h02000;
        default: div_ratio = 17'h10000;
      endcase
    end
  endfunction

  function [3:0] trim_state;
    input [3:0] code;
    begin
      case (code)
        4'h0:    trim_state = 4'hA;
        4'h1:    trim_state = 4'h9;
        4'h8:    trim_state = 4'h8;
        4'h9:    trim_state = 4'h7;
        4'hC:    trim_state = 4'h6;
        4'hE:    trim_state = 4'h4;
        4'hF:    trim_state = 4'h3;
        4'h6:    trim_state = 4'h2;
        4'h7:    trim_state = 4'h1;
        default: trim_state = `RCW_TRIM_NOMINAL;
      endcase
    end
  endfunction

  // clock cycles per lock step, held at the counter width
  localparam [15:0] LOCK_STEP_CYC = `RCW_LOCK_STEP_CYC;

  // longest wait is 255 steps, which still fits the 16-bit counter
  function [15:0] lock_cycles;
    input [7:0] steps;
    begin
      lock_cycles = {8'h00, steps} * LOCK_STEP_CYC;
    end
  endfunction

  // ****************************************
  // register file
  // ****************************************
  reg  [7:0]  test_cont_r;
  reg  [2:0]  speed_r;
  reg  [7:0]  rx_lock_r;
  reg  [7:0]  tx_lock_r;
  reg  [5:0]  amp_level_r;
  reg  [7:0]  wake_cfg_hi_r;
  reg         wake_arm_r;
  reg  [7:0]  reload_hi_pend_r;
  reg  [15:0] reload_r;
  reg         reload_load_r;

  wire wr_hit_lo = reg_wr && (reg_addr == `RCW_ADDR_WAKE_VAL_LO);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rssi_settle_delay <= `RCW_RST_BYTE;
      test_cont_r       <= `RCW_RST_BYTE;
      speed_r           <= 3'h0;
      rx_lock_r         <= `RCW_RST_BYTE;
      tx_lock_r         <= `RCW_RST_BYTE;
      amp_level_r       <= 6'h00;
      wake_cfg_hi_r     <= `RCW_RST_BYTE;
      wake_arm_r        <= 1'b0;
      reload_hi_pend_r  <= `RCW_RST_BYTE;
      reload_r          <= 16'h0000;
      reload_load_r     <= 1'b0;
    end else begin
      reload_load_r <= 1'b0;
      if (sleep_state) begin
        amp_level_r      <= 6'h00;
        wake_cfg_hi_r    <= `RCW_RST_BYTE;
        wake_arm_r       <= 1'b0;
        reload_hi_pend_r <= `RCW_RST_BYTE;
        reload_r         <= 16'h0000;
      end else if (reg_wr) begin
        case (reg_addr)
          `RCW_ADDR_RSSI_SETTLE: rssi_settle_delay <= reg_wdata;
          `RCW_ADDR_TEST_CONT:   test_cont_r       <= reg_wdata;
          `RCW_ADDR_TRANS_SPEED: speed_r           <= reg_wdata[`RCW_SPEED_MSB:0];
          `RCW_ADDR_RX_LOCK:     rx_lock_r         <= reg_wdata;
          `RCW_ADDR_TX_LOCK:     tx_lock_r         <= reg_wdata;
          `RCW_ADDR_FINE_AMP:    amp_level_r       <= reg_wdata[`RCW_AMP_LEVEL_MSB:0];
          `RCW_ADDR_WAKE_CFG_HI: wake_cfg_hi_r     <= {1'b0, reg_wdata[6:0]};
          `RCW_ADDR_WAKE_CFG_LO: wake_arm_r        <= reg_wdata[`RCW_WAKE_ARM_BIT];
          `RCW_ADDR_WAKE_VAL_HI: reload_hi_pend_r  <= reg_wdata;
          `RCW_ADDR_WAKE_VAL_LO: begin
            reload_r      <= {reload_hi_pend_r, reg_wdata};
            reload_load_r <= 1'b1;
          end
          default: reload_load_r <= 1'b0;
        endcase
      end
    end
  end

  // write-only and unmapped addresses read as zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `RCW_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `RCW_ADDR_RSSI_SETTLE: reg_rdata <= rssi_settle_delay;
        `RCW_ADDR_TEST_CONT:   reg_rdata <= test_cont_r;
        `RCW_ADDR_TRANS_SPEED: reg_rdata <= {5'h00, speed_r};
        `RCW_ADDR_RX_LOCK:     reg_rdata <= rx_lock_r;
        `RCW_ADDR_TX_LOCK:     reg_rdata <= tx_lock_r;
        `RCW_ADDR_FINE_AMP:    reg_rdata <= {2'h0, amp_level_r};
        default:               reg_rdata <= `RCW_RST_BYTE;
      endcase
    end
  end

  // ****************************************
  // amplifier pins, packet restart, speed
  // ****************************************
  wire amp_sel = test_cont_r[`RCW_AMP_PIN_SEL_BIT];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      analog_test_pin_three_out <= 1'b0;
      analog_test_pin_three_oe  <= 1'b0;
      analog_test_pin_four_out  <= 1'b0;
      analog_test_pin_four_oe   <= 1'b0;
      slow_crystal_pin_p_out    <= 1'b0;
      slow_crystal_pin_p_oe     <= 1'b0;
      slow_crystal_pin_n_out    <= 1'b0;
      slow_crystal_pin_n_oe     <= 1'b0;
      tx_restart                <= 1'b0;
      rx_restart                <= 1'b0;
      tx_finish                 <= 1'b0;
      rx_finish                 <= 1'b0;
      fast_transition           <= 1'b0;
      amp_target_level          <= 6'h00;
      rc_trim_state             <= `RCW_TRIM_NOMINAL;
    end else begin
      analog_test_pin_three_oe  <= ext_amp_enable && amp_sel;
      analog_test_pin_four_oe   <= ext_amp_enable && amp_sel;
      slow_crystal_pin_p_oe     <= ext_amp_enable && !amp_sel;
      slow_crystal_pin_n_oe     <= ext_amp_enable && !amp_sel;
      analog_test_pin_three_out <= ext_amp_enable && amp_sel && ext_pa_ctrl;
      analog_test_pin_four_out  <= ext_amp_enable && amp_sel && ext_lna_ctrl;
      slow_crystal_pin_p_out    <= ext_amp_enable && !amp_sel && ext_pa_ctrl;
      slow_crystal_pin_n_out    <= ext_amp_enable && !amp_sel && ext_lna_ctrl;
      tx_restart <= tx_packet_done && test_cont_r[`RCW_REPEAT_TX_BIT];
      tx_finish  <= tx_packet_done && !test_cont_r[`RCW_REPEAT_TX_BIT];
      rx_restart <= rx_packet_done && test_cont_r[`RCW_REPEAT_RX_BIT];
      rx_finish  <= rx_packet_done && !test_cont_r[`RCW_REPEAT_RX_BIT];
      fast_transition <= (speed_r == `RCW_SPEED_FAST);
      // levels below 2 are not valid, so lift to minimum
      amp_target_level <= (amp_level_r < `RCW_AMP_LEVEL_MIN) ? `RCW_AMP_LEVEL_MIN
                                                             : amp_level_r;
      rc_trim_state <= trim_state(wake_cfg_hi_r[`RCW_TRIM_MSB:`RCW_TRIM_LSB]);
    end
  end

  // ****************************************
  // synthesizer lock wait
  // ****************************************
  reg  [15:0] lock_cnt_r;
  reg         lock_busy_r;
  wire [7:0]  lock_steps = !custom_lock_time_enable ? `RCW_LOCK_DEFAULT_STEPS :
                           synth_rx_mode ? rx_lock_r : tx_lock_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt_r      <= 16'h0000;
      lock_busy_r     <= 1'b0;
      synth_lock_done <= 1'b0;
    end else begin
      synth_lock_done <= 1'b0;
      if (vco_cal_done) begin
        lock_cnt_r  <= lock_cycles(lock_steps);
        lock_busy_r <= 1'b1;
      end else if (lock_busy_r) begin
        if (lock_cnt_r == 16'h0000) begin
          lock_busy_r     <= 1'b0;
          synth_lock_done <= 1'b1;
        end else begin
          lock_cnt_r <= lock_cnt_r - 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // wake timer
  // ****************************************
  reg  [16:0] div_cnt_r;
  reg  [15:0] timer_r;
  reg         slow_s1_r;
  reg         slow_s2_r;
  reg         slow_s3_r;
  wire        slow_edge = slow_s2_r && !slow_s3_r;
  wire [16:0] ratio     = div_ratio(wake_cfg_hi_r[`RCW_DIV_MSB:0]);
  wire        tick      = slow_edge && (div_cnt_r == ratio - 17'h00001);
  wire [15:0] timer_nxt = (timer_r == 16'h0000) ? reload_r : timer_r - 16'h0001;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slow_s1_r  <= 1'b0;
      slow_s2_r  <= 1'b0;
      slow_s3_r  <= 1'b0;
      div_cnt_r  <= 17'h00000;
      timer_r    <= 16'h0000;
      wake_event <= 1'b0;
    end else begin
      slow_s1_r  <= slow_clk_in;
      slow_s2_r  <= slow_s1_r;
      slow_s3_r  <= slow_s2_r;
      wake_event <= 1'b0;
      if (tick || (div_cnt_r >= ratio)) begin
        div_cnt_r <= 17'h00000;
      end else if (slow_edge) begin
        div_cnt_r <= div_cnt_r + 17'h00001;
      end
      if (reload_load_r) begin
        timer_r <= reload_r;
      end else if (tick) begin
        timer_r    <= timer_nxt;
        wake_event <= wake_arm_r && (timer_nxt == 16'h0000);
      end
    end
  end

endmodule // rcw_regs
`default_nettype wire

// ===== rcw_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"
// ********
// bus, pulse and timer checks
// ********
module rcw_regs_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [10:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  rssi_settle_delay,
  input wire logic        sleep_state,
  input wire logic        ext_amp_enable,
  input wire logic        ext_pa_ctrl,
  input wire logic        analog_test_pin_three_out,
  input wire logic        analog_test_pin_three_oe,
  input wire logic        slow_crystal_pin_p_oe,
  input wire logic        tx_packet_done,
  input wire logic        rx_packet_done,
  input wire logic        tx_restart,
  input wire logic        tx_finish,
  input wire logic        rx_restart,
  input wire logic        rx_finish,
  input wire logic        vco_cal_done,
  input wire logic        synth_lock_done,
  input wire logic [5:0]  amp_target_level,
  input wire logic        wake_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [15:0] lock_cnt_r;
  // cycles since the lock wait was taken; wide enough for the longest wait
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      lock_cnt_r <= 16'h0000;
    else
      lock_cnt_r <= vco_cal_done ? 16'h0000 : lock_cnt_r + 16'h0001;
  end
  a_read_latency: assert property (reg_rd && reg_addr == `RCW_ADDR_RSSI_SETTLE
    |=> reg_rdata == $past(rssi_settle_delay)) else $error("read data wrong");
  a_amp_route: assert property ((analog_test_pin_three_oe || slow_crystal_pin_p_oe)
    == $past(ext_amp_enable) && !(analog_test_pin_three_oe && slow_crystal_pin_p_oe))
    else $error("amp pin enable wrong");
  a_pa_follow: assert property (analog_test_pin_three_out
    == (analog_test_pin_three_oe && $past(ext_pa_ctrl))) else $error("pa pin level wrong");
  a_tx_answer: assert property ((tx_restart || tx_finish) == $past(tx_packet_done)
    && !(tx_restart && tx_finish)) else $error("tx end pulse wrong");
  a_rx_answer: assert property ((rx_restart || rx_finish) == $past(rx_packet_done)
    && !(rx_restart && rx_finish)) else $error("rx end pulse wrong");
  a_lock_step: assert property (synth_lock_done |-> lock_cnt_r % `RCW_LOCK_STEP_CYC == 1)
    else $error("lock wait length wrong");
  a_lock_gap: assert property (vco_cal_done |=> !synth_lock_done)
    else $error("lock done too early");
  a_sleep_clear: assert property (sleep_state [*2] |=> amp_target_level == 6'h02)
    else $error("sleep did not clear amp level");
  a_amp_floor: assert property ($past(nrst) |-> amp_target_level >= 6'h02)
    else $error("amp level below floor");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake event too long");
  cover property (synth_lock_done);
  cover property (wake_event);
  cover property (tx_packet_done ##1 tx_restart);
endmodule // rcw_regs_chk
bind rcw_regs rcw_regs_chk rcw_regs_chk_i (.*);
`default_nettype wire

// ===== rcw_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"
// ********
// host side of the register port
// ********
module rcw_host (
  input  wire logic        clk,
  output var  logic [10:0] reg_addr,
  output var  logic [7:0]  reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  input  wire logic [7:0]  reg_rdata
);
  initial begin
    reg_addr = 11'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines show inverted values so stale data is never mistaken for valid
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  task automatic cfg_wake(input logic [3:0] t, input logic [2:0] dv, input logic [15:0] rl,
                          input logic arm);
    wr(`RCW_ADDR_WAKE_CFG_HI, {1'b0, t, dv});
    wr(`RCW_ADDR_WAKE_VAL_HI, rl[15:8]);
    wr(`RCW_ADDR_WAKE_VAL_LO, rl[7:0]);
    wr(`RCW_ADDR_WAKE_CFG_LO, {7'h00, arm});
  endtask
endmodule // rcw_host
`default_nettype wire

// ===== rcw_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"
// ********
// register bank bench
// ********
module rcw_regs_tb;
  logic        clk = 1'b0, nrst = 1'b0, sleep_state = 1'b0, ext_amp_enable = 1'b0;
  logic        ext_pa_ctrl = 1'b0, ext_lna_ctrl = 1'b0, tx_packet_done = 1'b0;
  logic        rx_packet_done = 1'b0, custom_lock_time_enable = 1'b0, vco_cal_done = 1'b0;
  logic        synth_rx_mode = 1'b0, slow_clk_in = 1'b0, slow_en = 1'b0;
  wire  [10:0] reg_addr;
  wire  [7:0]  reg_wdata, reg_rdata, rssi_settle_delay, pins;
  wire  [5:0]  amp_target_level;
  wire  [3:0]  rc_trim_state, pk;
  wire         reg_wr, reg_rd, fast_transition, synth_lock_done, wake_event;
  int          num_errors = 0, checked = 0, wcnt = 0, n;
  logic [3:0]  trim_tab [16] = '{4'hA, 4'h9, 4'h5, 4'h5, 4'h5, 4'h5, 4'h2, 4'h1,
                                 4'h8, 4'h7, 4'h5, 4'h5, 4'h6, 4'h5, 4'h4, 4'h3};
  logic [7:0]  spd [3] = '{8'h04, 8'h01, 8'h00};
  logic [7:0]  amp [3] = '{8'h01, 8'h3F, 8'h02};
  rcw_host host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                   .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rcw_regs rcw_regs_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_state(sleep_state),
    .ext_amp_enable(ext_amp_enable), .ext_pa_ctrl(ext_pa_ctrl), .ext_lna_ctrl(ext_lna_ctrl),
    .analog_test_pin_three_out(pins[7]), .analog_test_pin_three_oe(pins[6]),
    .analog_test_pin_four_out(pins[5]), .analog_test_pin_four_oe(pins[4]),
    .slow_crystal_pin_p_out(pins[3]), .slow_crystal_pin_p_oe(pins[2]),
    .slow_crystal_pin_n_out(pins[1]), .slow_crystal_pin_n_oe(pins[0]),
    .tx_packet_done(tx_packet_done), .rx_packet_done(rx_packet_done), .tx_restart(pk[3]),
    .rx_restart(pk[1]), .tx_finish(pk[2]), .rx_finish(pk[0]),
    .fast_transition(fast_transition), .rssi_settle_delay(rssi_settle_delay),
    .custom_lock_time_enable(custom_lock_time_enable), .vco_cal_done(vco_cal_done),
    .synth_rx_mode(synth_rx_mode), .synth_lock_done(synth_lock_done),
    .amp_target_level(amp_target_level), .rc_trim_state(rc_trim_state),
    .slow_clk_in(slow_clk_in), .wake_event(wake_event));
  always #12.5 clk = ~clk;
  // slow clock sped up to 16 cycles so the timer windows stay short; moves off the sampling edge
  always begin
    repeat (8) @(negedge clk);
    if (slow_en) slow_clk_in = ~slow_clk_in;
  end
  always @(posedge clk) if (wake_event) wcnt++;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_i.rd(a, v);
    check("read data", v, e);
  endtask
  task automatic pkt(input logic [1:0] r);
    host_i.wr(`RCW_ADDR_TEST_CONT, {6'h00, r});
    @(negedge clk);
    tx_packet_done = 1'b1;
    rx_packet_done = 1'b1;
    @(negedge clk);
    tx_packet_done = 1'b0;
    rx_packet_done = 1'b0;
    check("packet end", pk, {r[1], ~r[1], r[0], ~r[0]});
  endtask
  task automatic lock(input logic cust, input logic rxm, input int exp);
    @(negedge clk);
    custom_lock_time_enable = cust;
    synth_rx_mode = rxm;
    vco_cal_done = 1'b1;
    @(negedge clk);
    vco_cal_done = 1'b0;
    n = 0;
    while (synth_lock_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("lock wait", n, exp);
  endtask
  task automatic wwin(input int lo, input int hi);
    wcnt = 0;
    repeat (1024) @(negedge clk);
    check("wake count", wcnt >= lo && wcnt <= hi, 1'b1);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(20000 * 25);
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rdchk(`RCW_ADDR_RSSI_SETTLE, 8'h00);
    rdchk(11'h200, 8'h00);
    check("amp level", amp_target_level, 8'h02);
    host_i.wr(`RCW_ADDR_RSSI_SETTLE, 8'hA7);
    rdchk(`RCW_ADDR_RSSI_SETTLE, 8'hA7);
    check("settle delay", rssi_settle_delay, 8'hA7);
    foreach (spd[i]) begin
      host_i.wr(`RCW_ADDR_TRANS_SPEED, spd[i]);
      @(negedge clk);
      check("fast", fast_transition, spd[i] == 8'h01);
    end
    for (int c = 0; c < 16; c++) begin
      host_i.wr(`RCW_ADDR_WAKE_CFG_HI, {1'b0, c[3:0], 3'h0});
      @(negedge clk);
      check("trim", rc_trim_state, trim_tab[c]);
    end
    rdchk(`RCW_ADDR_WAKE_CFG_HI, 8'h00);
    foreach (amp[i]) begin
      host_i.wr(`RCW_ADDR_FINE_AMP, amp[i]);
      @(negedge clk);
      check("amp level", amp_target_level, amp[i] < 8'h02 ? 8'h02 : amp[i]);
      rdchk(`RCW_ADDR_FINE_AMP, amp[i]);
    end
    @(negedge clk);
    sleep_state = 1'b1;
    host_i.wr(`RCW_ADDR_FINE_AMP, 8'h10);
    @(negedge clk);
    sleep_state = 1'b0;
    rdchk(`RCW_ADDR_FINE_AMP, 8'h00);
    rdchk(`RCW_ADDR_RSSI_SETTLE, 8'hA7);
    ext_amp_enable = 1'b1;
    ext_pa_ctrl = 1'b1;
    host_i.wr(`RCW_ADDR_TEST_CONT, 8'h80);
    @(negedge clk);
    check("pins", pins, 8'hD0);
    rdchk(`RCW_ADDR_TEST_CONT, 8'h80);
    ext_pa_ctrl = 1'b0;
    ext_lna_ctrl = 1'b1;
    for (int r = 0; r < 4; r++) pkt(r[1:0]);
    check("pins", pins, 8'h07);
    host_i.wr(`RCW_ADDR_RX_LOCK, 8'h01);
    host_i.wr(`RCW_ADDR_TX_LOCK, 8'h02);
    lock(1'b1, 1'b1, 1 * `RCW_LOCK_STEP_CYC + 1);
    lock(1'b1, 1'b0, 2 * `RCW_LOCK_STEP_CYC + 1);
    lock(1'b0, 1'b0, `RCW_LOCK_DEFAULT_STEPS * `RCW_LOCK_STEP_CYC + 1);
    slow_en = 1'b1;
    host_i.cfg_wake(4'hD, 3'h0, 16'h0001, 1'b1);
    host_i.wr(`RCW_ADDR_WAKE_VAL_HI, 8'h01);
    wwin(31, 33);
    host_i.cfg_wake(4'hD, 3'h1, 16'h0001, 1'b1);
    wwin(7, 9);
    host_i.cfg_wake(4'hD, 3'h1, 16'h0001, 1'b0);
    wwin(0, 0);
    print_verdict;
  end
endmodule // rcw_regs_tb
`default_nettype wire
